// ===== design/acr_cmd_decode.sv
// command byte decoder for the register bank
// assumes a byte that is valid only in the cycle its strobe is high
`default_nettype none
module acr_cmd_decode (
    input wire logic [7:0] cmd_byte,
    output logic is_read,
    output logic is_write,
    output logic reg_sel
);
    assign is_read = (cmd_byte & acr_pkg::CMD_READ_MASK) == acr_pkg::CMD_READ_VAL;
    assign is_write = (cmd_byte & acr_pkg::CMD_WRITE_MASK) == acr_pkg::CMD_WRITE_VAL;
    assign reg_sel = cmd_byte[acr_pkg::CMD_REG_BIT];
endmodule
`default_nettype wire

// ===== design/acr_pkg.sv
// constants for the converter setup and result state register bank
// assumes a synchronous command port from an already decoded serial link
`default_nettype none
package acr_pkg;
    localparam logic [7:0] CMD_READ_MASK = 8'hF8;
    localparam logic [7:0] CMD_READ_VAL = 8'h20;
    localparam logic [7:0] CMD_WRITE_MASK = 8'hFC;
    localparam logic [7:0] CMD_WRITE_VAL = 8'h40;
    localparam int CMD_REG_BIT = 2;
    localparam logic ADDR_SETUP = 1'b0;
    localparam logic ADDR_STATE = 1'b1;
    localparam logic [7:0] SETUP_RESET = 8'h00;
    localparam logic [6:0] RESERVED_VALUE = 7'h00;
    localparam int PAIR_MSB = 7;
    localparam int PAIR_LSB = 5;
    localparam int GAIN_BIT = 4;
    localparam int RATE_MSB = 3;
    localparam int RATE_LSB = 2;
    localparam int MODE_BIT = 1;
    localparam int REF_BIT = 0;
endpackage
`default_nettype wire

// ===== design/acr_regs.sv
// converter setup and result state register bank
// assumes the serial framing outside hands over command and data bytes
// Notes on behaviour
// - two eight-bit registers, setup and state
// - reset clears both registers to zero
// - power-down keeps every register value
// - setup at address 0, fixed field layout
// - three-bit input pair select field
// - gain bit: 0 gives 1, 1 gives 4
// - two-bit rate select, 20 to 1000 SPS
// - mode bit: single-shot or continuous
// - reference bit: internal or external pins
// - state at address 1, read-only, bit 7 flag
// - flag set on result, cleared on data read
// - read command picks register, returns byte
// - write command plus byte updates setup only
// - setup write restarts filter and conversion
`default_nettype none
module acr_regs (
    input wire logic clk,
    input wire logic rst,
    input wire logic cmd_valid,
    input wire logic [7:0] cmd_byte,
    input wire logic data_valid,
    input wire logic [7:0] data_byte,
    input wire logic result_done,
    input wire logic data_read,
    input wire logic power_down,
    output logic [7:0] read_byte,
    output logic read_valid,
    output logic [2:0] input_pair_select,
    output logic gain_select,
    output logic [1:0] rate_select,
    output logic conversion_mode_bit,
    output logic reference_select,
    output logic filter_restart,
    output logic new_result_flag
);
    ////////////////////////////////////////////////////////////////////
    logic [7:0] converter_setup;
    logic write_pending;
    logic dec_read;
    logic dec_write;
    logic dec_sel;
    logic take_read;
    logic take_write;
    logic setup_write;
    logic [7:0] result_state;
    logic [7:0] next_read_byte;

    acr_cmd_decode u_dec (
        .cmd_byte(cmd_byte),
        .is_read(dec_read),
        .is_write(dec_write),
        .reg_sel(dec_sel)
    );

    assign take_read = cmd_valid && dec_read;
    assign take_write = cmd_valid && dec_write;
    assign setup_write = write_pending && data_valid && !cmd_valid;
    // flag on top, reserved bits below
    assign result_state = {new_result_flag, acr_pkg::RESERVED_VALUE};
    assign next_read_byte = (dec_sel == acr_pkg::ADDR_STATE) ? result_state : converter_setup;

    ////////////////////////////////////////////////////////////////////
    // zero on reset
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            converter_setup <= acr_pkg::SETUP_RESET;
            write_pending <= 1'b0;
        end else begin
            // only setup has a write path
            if (setup_write) begin
                converter_setup <= data_byte;
            end
            if (cmd_valid) begin
                write_pending <= dec_write;
            end else if (data_valid) begin
                write_pending <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            filter_restart <= 1'b0;
        end else begin
            filter_restart <= setup_write;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            new_result_flag <= 1'b0;
        end else if (result_done) begin
            new_result_flag <= 1'b1;
        end else if (data_read) begin
            new_result_flag <= 1'b0;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            read_byte <= acr_pkg::SETUP_RESET;
            read_valid <= 1'b0;
        end else begin
            read_valid <= take_read;
            if (take_read) begin
                read_byte <= next_read_byte;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // field outputs from setup register
    assign input_pair_select = converter_setup[acr_pkg::PAIR_MSB:acr_pkg::PAIR_LSB];
    assign gain_select = converter_setup[acr_pkg::GAIN_BIT];
    assign rate_select = converter_setup[acr_pkg::RATE_MSB:acr_pkg::RATE_LSB];
    assign conversion_mode_bit = converter_setup[acr_pkg::MODE_BIT];
    assign reference_select = converter_setup[acr_pkg::REF_BIT];

    logic unused_ok;
    assign unused_ok = power_down & take_write;
endmodule
`default_nettype wire

// ===== verification/acr_host.sv
// host model driving command and data bytes
// one byte per clock, released lines show their own last byte inverted
`default_nettype none
module acr_host (
    input wire logic clk,
    output logic cmd_valid = 0,
    output logic [7:0] cmd_byte = 8'h00,
    output logic data_valid = 0,
    output logic [7:0] data_byte = 8'h00
);
    timeunit 1ns;
    timeprecision 1ns;
    task automatic put(input logic cv, input logic dv, input logic [7:0] b);
        cmd_valid <= cv;
        data_valid <= dv;
        cmd_byte <= cv ? b : ~cmd_byte;
        data_byte <= dv ? b : ~data_byte;
        @(posedge clk);
    endtask
endmodule
`default_nettype wire

// ===== verification/acr_regs_bench.sv
// self-checking bench for the register bank
// assumes the host model drives the command port
`default_nettype none
module acr_regs_bench;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 0, rst = 1, result_done = 0, data_read = 0, power_down = 0, f = 0, junk;
    logic cmd_valid, data_valid, read_valid, filter_restart, new_result_flag;
    logic gain_select, conversion_mode_bit, reference_select;
    logic [7:0] cmd_byte, data_byte, read_byte, s = 8'h00, d;
    logic [2:0] input_pair_select;
    logic [1:0] rate_select;
    logic [31:0] r = 32'hEA04379A;
    int n_errors = 0, n_checks = 0;
    wire logic [7:0] setup = {input_pair_select, gain_select, rate_select, conversion_mode_bit, reference_select};
    acr_host i_host (.clk(clk), .cmd_valid(cmd_valid), .cmd_byte(cmd_byte), .data_valid(data_valid),
        .data_byte(data_byte));
    acr_regs i_dut (.*);
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return x[0] ? (x >> 1) ^ 32'h80200003 : x >> 1;
    endfunction
    function automatic logic nflag(input logic q, input logic set, input logic clr);
        return set | (q & ~clr);
    endfunction
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("wrong value at %0t: got %h want %h", $time, seen, exp);
        end
    endtask
    task automatic print_verdict;
        if (n_errors == 0 && n_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    initial forever #25 clk = ~clk;
    initial begin
        #60000;
        n_errors++;
        print_verdict;
    end
    initial begin
        repeat (2) @(posedge clk);
        rst <= 0;
        #1 chk(setup, 8'h00);
        for (int i = 0; i < 40; i++) begin
            r = lfsr(r);
            d = r[15:8];
            junk = r[16];
            i_host.put(1, 0, {6'h10, r[1:0]});
            if (junk) i_host.put(1, 0, r[17] ? 8'h44 : 8'h10);
            power_down <= r[2];
            i_host.put(0, 1, d);
            s = junk ? s : d;
            #1 chk(setup, s);
            chk({7'h00, filter_restart}, {7'h00, ~junk});
            i_host.put(1, 0, {5'h04, 1'b0, r[5:4]});
            #1 chk(read_byte, s);
            result_done <= r[6];
            data_read <= r[7];
            i_host.put(1, 0, {5'h04, 1'b1, r[5:4]});
            #1 chk({7'h00, read_byte[7]}, {7'h00, f});
            f = nflag(f, r[6], r[7]);
            result_done <= 0;
            data_read <= 0;
            i_host.put(0, 0, 8'h00);
            #1 chk({7'h00, new_result_flag}, {7'h00, f});
        end
        rst <= 1;
        repeat (2) @(posedge clk);
        rst <= 0;
        #1 chk(setup, 8'h00);
        chk({7'h00, new_result_flag}, 8'h00);
        print_verdict;
    end
endmodule
`default_nettype wire

// ===== verification/acr_regs_monitor.sv
// assertions on the register bank ports
// bound into acr_regs
`default_nettype none
module acr_regs_monitor (
    input wire logic clk, rst, cmd_valid, data_valid, result_done, data_read, filter_restart, new_result_flag,
    input wire logic read_valid, gain_select, conversion_mode_bit, reference_select,
    input wire logic [7:0] cmd_byte, read_byte,
    input wire logic [2:0] input_pair_select,
    input wire logic [1:0] rate_select
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    wire logic rd = cmd_valid && cmd_byte[7:3] == 5'h04;
    wire logic [7:0] setup = {input_pair_select, gain_select, rate_select, conversion_mode_bit, reference_select};
    read_answer_a: assert property (rd |=> read_valid) else $error("read lost");
    stray_read_a: assert property (!rd |=> !read_valid) else $error("stray read");
    state_byte_a: assert property (rd && cmd_byte[2] |=> read_byte == {$past(new_result_flag), 7'h00}) else $error("bad state");
    restart_cause_a: assert property (filter_restart |-> $past(data_valid)) else $error("stray restart");
    flag_set_a: assert property (result_done |=> new_result_flag) else $error("flag unset");
    flag_clear_a: assert property (data_read && !result_done |=> !new_result_flag) else $error("flag kept");
    flag_hold_a: assert property (!result_done && !data_read |=> $stable(new_result_flag)) else $error("flag moved");
    fields_hold_a: assert property (!filter_restart |-> $stable(setup)) else $error("setup moved");
endmodule
bind acr_regs acr_regs_monitor i_mon (.*);
`default_nettype wire
